// ==== core/sfc_commutator.sv ====
// Single-phase fan commutator with speed PWM and lock restart
// What this block does
// RULE1 - Hall positive above negative selects phase B
// RULE2 - Command 3V gives 0%, 1V 100%
// RULE3 - Command above 0% level forces drive off
// RULE4 - Grounded command gives continuous full drive
// RULE5 - Effective command clamped to minimum-speed setting
// RULE6 - Default commutation delay nominally 100 microseconds
// RULE7 - Delay selectable between 28 and 168 microseconds
// RULE8 - PWM period is charge plus discharge ramp
// RULE9 - Nominal PWM frequency about 24 kHz
// RULE10 - After lock time, flag and disable outputs
// RULE11 - While locked alternate wait and restart drive
// RULE12 - Restart to wait ratio about 1:12
// RULE13 - Lock, restart, wait times follow ramp ratios
// RULE14 - Lock flag high when stopped, pull-down only
// RULE15 - Tach output copies Hall, pull-down only
// RULE16 - Low sides carry commutation and PWM together
// RULE17 - Inactive phase low side held low
// RULE18 - High sides commutation only, pull-down drive
// RULE19 - All four bridge drive outputs off for delay at transition
// RULE20 - Hall transition restarts timer, ends lock
// RULE21 - Codes compared with triangle, timing from ticks
`timescale 1ns/1ns
module sfc_commutator
	import sfc_pkg::*;
#(
	parameter int unsigned LOCK_US = sfc_pkg::LOCK_US_DEF,
	parameter int unsigned ON_US = sfc_pkg::ON_US_DEF,
	parameter int unsigned OFF_US = sfc_pkg::OFF_US_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [sfc_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [sfc_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [sfc_pkg::CODE_W-1:0] hall_pos_level,
	input wire logic [sfc_pkg::CODE_W-1:0] hall_neg_level,
	output logic low_side_drive_a,
	output logic low_side_drive_b,
	output logic high_side_drive_a_oe,
	output logic high_side_drive_b_oe,
	output logic tach_pulse_out_oe,
	output logic rotor_locked_oe
);
	import sfc_pkg::*;

	default clocking dcb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [7:0] speed_command_in_reg;
	logic [7:0] min_speed_limit_reg;
	logic [2:0] commutation_delay_adjust_reg;
	logic [AXI_AW-1:0] aw_addr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_go;
	logic wr_hit;
	logic [31:0] rd_word;
	logic rd_hit;
	logic us_tick;
	logic hall_sel_reg;
	logic hall_now;
	logic hall_edge;
	sfc_state_t state_reg;
	logic [7:0] dly_cnt_reg;
	logic [7:0] dly_tgt;
	logic dly_done;
	logic [31:0] lk_cnt_reg;
	logic [31:0] lk_tgt;
	logic lk_done;
	logic locked_reg;
	logic [7:0] tri_reg;
	logic dir_up_reg;
	logic [7:0] step_cnt_reg;
	logic [7:0] step_len;
	logic [7:0] eff_cmd;
	logic pwm_on;
	logic drive_en;
	logic [15:0] hi_len_reg;

	sfc_tick_div #(
		.DIV(TICK_CYC)
	) u_us_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(us_tick)
	);

	// ---------------------------------------------------------------
	// AXI4-Lite write channel
	// ---------------------------------------------------------------
	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	// Status is read only: a write there is ignored but answered OKAY
	assign wr_hit = aw_addr_reg == OFS_SPEED ||
		aw_addr_reg == OFS_MIN_SPEED || aw_addr_reg == OFS_DELAY ||
		aw_addr_reg == OFS_STATUS;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			aw_addr_reg <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_addr_reg <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Fields are at most one byte wide, so only lane 0 matters
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			speed_command_in_reg <= RST_SPEED;
			min_speed_limit_reg <= RST_MIN_SPEED;
			commutation_delay_adjust_reg <= RST_DELAY;
		end else if (wr_go && wstrb_reg[0]) begin
			unique case (aw_addr_reg)
				OFS_SPEED: speed_command_in_reg <= wdata_reg[7:0];
				OFS_MIN_SPEED: min_speed_limit_reg <= wdata_reg[7:0];
				OFS_DELAY: commutation_delay_adjust_reg <= wdata_reg[2:0];
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read channel
	// ---------------------------------------------------------------
	always_comb begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			OFS_SPEED: rd_word[7:0] = speed_command_in_reg;
			OFS_MIN_SPEED: rd_word[7:0] = min_speed_limit_reg;
			OFS_DELAY: rd_word[2:0] = commutation_delay_adjust_reg;
			OFS_STATUS: rd_word[6:0] =
				{pwm_on, state_reg, hall_sel_reg, locked_reg};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Hall comparator and commutation sequence
	// ---------------------------------------------------------------
	assign hall_now = hall_pos_level > hall_neg_level; // RULE1
	assign hall_edge = hall_now != hall_sel_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hall_sel_reg <= 1'b0;
		end else begin
			hall_sel_reg <= hall_now; // RULE1
		end
	end

	always_comb begin
		unique case (commutation_delay_adjust_reg)
			DSEL_SHORTEST: dly_tgt = DLY_SHORTEST_US; // RULE7
			DSEL_SHORT: dly_tgt = DLY_SHORT_US; // RULE7
			DSEL_LONG: dly_tgt = DLY_LONG_US; // RULE7
			DSEL_LONGEST: dly_tgt = DLY_LONGEST_US; // RULE7
			default: dly_tgt = DLY_NOM_US; // RULE6
		endcase
	end

	always_comb begin
		unique case (state_reg)
			S_WAIT: lk_tgt = OFF_US; // RULE12 RULE13
			S_RESTART: lk_tgt = ON_US; // RULE12 RULE13
			default: lk_tgt = LOCK_US; // RULE13
		endcase
	end

	assign dly_done = us_tick && dly_cnt_reg == dly_tgt - 8'h01;
	assign lk_done = us_tick && lk_cnt_reg == lk_tgt - 32'h00000001;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= S_DELAY;
		end else if (hall_edge) begin
			state_reg <= S_DELAY; // RULE19 RULE20
		end else begin
			unique case (state_reg)
				S_DELAY: if (dly_done) begin
					state_reg <= S_RUN; // RULE19
				end
				S_RUN: if (lk_done) begin
					state_reg <= S_WAIT; // RULE10
				end
				S_WAIT: if (lk_done) begin
					state_reg <= S_RESTART; // RULE11
				end
				S_RESTART: if (lk_done) begin
					state_reg <= S_WAIT; // RULE11
				end
			endcase
		end
	end

	// Delay counts microsecond ticks from the transition
	always_ff @(posedge aclk) begin
		if (!aresetn || hall_edge || state_reg != S_DELAY) begin
			dly_cnt_reg <= 8'h00; // RULE21
		end else if (us_tick) begin
			dly_cnt_reg <= dly_cnt_reg + 8'h01; // RULE6
		end
	end

	// One counter times lock detect, wait and restart
	always_ff @(posedge aclk) begin
		if (!aresetn || hall_edge || lk_done || state_reg == S_DELAY) begin
			lk_cnt_reg <= 32'h00000000; // RULE20
		end else if (us_tick) begin
			lk_cnt_reg <= lk_cnt_reg + 32'h00000001; // RULE21
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || hall_edge) begin
			locked_reg <= 1'b0; // RULE20
		end else if (state_reg == S_RUN && lk_done) begin
			locked_reg <= 1'b1; // RULE10
		end
	end

	// ---------------------------------------------------------------
	// PWM triangle: slow charge up, fast discharge down
	// ---------------------------------------------------------------
	assign step_len = dir_up_reg ? PWM_UP_STEP_CYC : PWM_DN_STEP_CYC;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tri_reg <= LVL_LO_CODE;
			dir_up_reg <= 1'b1;
			step_cnt_reg <= 8'h00;
		end else if (step_cnt_reg >= step_len - 8'h01) begin
			step_cnt_reg <= 8'h00; // RULE8 RULE9
			if (dir_up_reg) begin
				tri_reg <= tri_reg + 8'h01;
				dir_up_reg <= tri_reg + 8'h01 != LVL_HI_CODE; // RULE8
			end else begin
				tri_reg <= tri_reg - 8'h01;
				dir_up_reg <= tri_reg - 8'h01 == LVL_LO_CODE; // RULE8
			end
		end else begin
			step_cnt_reg <= step_cnt_reg + 8'h01;
		end
	end

	// Lower code means faster; the minimum-speed code caps it
	assign eff_cmd = speed_command_in_reg < min_speed_limit_reg ?
		speed_command_in_reg : min_speed_limit_reg; // RULE5
	// Triangle never passes the high level, so codes there give 0%
	assign pwm_on = eff_cmd <= LVL_LO_CODE || // RULE4
		eff_cmd < tri_reg; // RULE2 RULE3 RULE21
	assign drive_en = state_reg == S_RUN || state_reg == S_RESTART;

	// ---------------------------------------------------------------
	// Output drivers
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_side_drive_a <= 1'b0;
			low_side_drive_b <= 1'b0;
		end else begin
			low_side_drive_a <= drive_en && !hall_sel_reg && pwm_on; // RULE16
			low_side_drive_b <= drive_en && hall_sel_reg && pwm_on; // RULE17
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_side_drive_a_oe <= 1'b0;
			high_side_drive_b_oe <= 1'b0;
		end else begin
			high_side_drive_a_oe <= drive_en && !hall_sel_reg; // RULE18
			high_side_drive_b_oe <= drive_en && hall_sel_reg; // RULE18
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tach_pulse_out_oe <= 1'b1;
			rotor_locked_oe <= 1'b1;
		end else begin
			tach_pulse_out_oe <= !hall_sel_reg; // RULE15
			rotor_locked_oe <= !locked_reg; // RULE14
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_inactive_low_a: assert property ( // RULE17
		$past(hall_sel_reg) |-> !low_side_drive_a && !high_side_drive_a_oe)
		else $error("phase A driven while phase B selected");

	a_disable_off: assert property ( // RULE3
		$past(eff_cmd >= LVL_HI_CODE) |->
		!low_side_drive_a && !low_side_drive_b)
		else $error("low side pulsed with command at off level");

	a_full_drive: assert property ( // RULE4
		$past(eff_cmd <= LVL_LO_CODE && drive_en) |->
		low_side_drive_a != low_side_drive_b)
		else $error("full command did not drive active low side");

	a_comm_gap: assert property ( // RULE19
		$changed(hall_sel_reg) |-> state_reg == S_DELAY ##1
		(!high_side_drive_a_oe && !high_side_drive_b_oe &&
		!low_side_drive_a && !low_side_drive_b) [*3])
		else $error("drive not removed at Hall transition");

	a_delay_len: assert property ( // RULE6
		state_reg == S_RUN && $past(state_reg) == S_DELAY |->
		$past(dly_cnt_reg) + 8'h01 == $past(dly_tgt) && $past(us_tick))
		else $error("commutation delay ended at wrong count");

	a_lock_rise: assert property ( // RULE10
		$rose(locked_reg) |-> state_reg == S_WAIT &&
		$past(lk_cnt_reg) == LOCK_US - 1 ##1 !high_side_drive_a_oe &&
		!high_side_drive_b_oe && !rotor_locked_oe)
		else $error("lock flag without full lock time");

	a_locked_cycle: assert property ( // RULE11
		state_reg == S_WAIT |=> !high_side_drive_a_oe &&
		!high_side_drive_b_oe && !low_side_drive_a && !low_side_drive_b)
		else $error("drive active during locked wait");

	a_restart_order: assert property ( // RULE11
		state_reg == S_RESTART |-> locked_reg &&
		$past(state_reg) inside {S_WAIT, S_RESTART})
		else $error("restart drive outside locked cycle");

	a_lock_clear: assert property ( // RULE20
		$changed(hall_sel_reg) |-> !locked_reg && lk_cnt_reg == 0
		##1 rotor_locked_oe)
		else $error("Hall transition did not end lock");

	a_tach_copy: assert property ( // RULE15
		$past(hall_now, 2) == !tach_pulse_out_oe)
		else $error("tach output does not follow Hall");

	a_high_no_pwm: assert property ( // RULE18
		state_reg == S_RUN && $stable(state_reg) &&
		!$changed(hall_sel_reg) |=> $stable(high_side_drive_a_oe) &&
		$stable(high_side_drive_b_oe))
		else $error("high side toggled within a phase");

	c_lock_entry: cover property (state_reg == S_RUN ##1
		state_reg == S_WAIT);
	c_restart: cover property (state_reg == S_WAIT ##1
		state_reg == S_RESTART);
	c_commutate: cover property ($changed(hall_sel_reg) ##[1:200]
		state_reg == S_RUN);
	// Length of the current phase B low-side pulse, for the cover below
	always_ff @(posedge aclk) begin
		if (!aresetn || !low_side_drive_b) begin
			hi_len_reg <= 16'h0000;
		end else begin
			hi_len_reg <= hi_len_reg + 16'h0001;
		end
	end

	c_pwm_pulse: cover property ($fell(low_side_drive_b) &&
		hi_len_reg > 16'h0064);

endmodule

// ==== core/sfc_pkg.sv ====
// Shared constants and types for the fan commutator block
package sfc_pkg;

	// ---------------------------------------------------------------
	// Clock and time base
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TICK_NS = 1000;
	localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// Analog levels as codes, 50 codes per volt
	// ---------------------------------------------------------------
	localparam int unsigned CODE_W = 8;
	localparam logic [7:0] LVL_LO_CODE = 8'h32;
	localparam logic [7:0] LVL_HI_CODE = 8'h96;
	localparam logic [7:0] LVL_REF_CODE = 8'hFA;

	// ---------------------------------------------------------------
	// PWM triangle: charge ramp up, discharge ramp down
	// ---------------------------------------------------------------
	localparam int unsigned PWM_UP_NS = 38200;
	localparam int unsigned PWM_DN_NS = 3460;
	localparam int unsigned PWM_STEPS = 100;
	localparam logic [7:0] PWM_UP_STEP_CYC =
		8'(PWM_UP_NS / (CLK_PERIOD_NS * PWM_STEPS));
	localparam logic [7:0] PWM_DN_STEP_CYC =
		8'(PWM_DN_NS / (CLK_PERIOD_NS * PWM_STEPS));

	// ---------------------------------------------------------------
	// Commutation delay, in microseconds
	// ---------------------------------------------------------------
	localparam logic [7:0] DLY_NOM_US = 8'h64;
	localparam logic [7:0] DLY_SHORTEST_US = 8'h1C;
	localparam logic [7:0] DLY_SHORT_US = 8'h28;
	localparam logic [7:0] DLY_LONG_US = 8'h78;
	localparam logic [7:0] DLY_LONGEST_US = 8'hA8;
	localparam logic [2:0] DSEL_NOM = 3'h0;
	localparam logic [2:0] DSEL_SHORTEST = 3'h1;
	localparam logic [2:0] DSEL_SHORT = 3'h2;
	localparam logic [2:0] DSEL_LONG = 3'h3;
	localparam logic [2:0] DSEL_LONGEST = 3'h4;

	// ---------------------------------------------------------------
	// Lock detect and restart timing, in microseconds
	// ---------------------------------------------------------------
	localparam int unsigned LOCK_US_DEF = 840000;
	localparam int unsigned ON_US_DEF = 560000;
	localparam int unsigned OFF_US_DEF = 6800000;

	// ---------------------------------------------------------------
	// Register map and reset values
	// ---------------------------------------------------------------
	localparam int unsigned AXI_AW = 8;
	localparam logic [7:0] OFS_SPEED = 8'h00;
	localparam logic [7:0] OFS_MIN_SPEED = 8'h04;
	localparam logic [7:0] OFS_DELAY = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] RST_SPEED = 8'h00;
	localparam logic [7:0] RST_MIN_SPEED = LVL_REF_CODE;
	localparam logic [2:0] RST_DELAY = DSEL_NOM;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		S_DELAY = 4'h1,
		S_RUN = 4'h2,
		S_WAIT = 4'h4,
		S_RESTART = 4'h8
	} sfc_state_t;

endpackage

// ==== core/sfc_tick_div.sv ====
// Divider that emits a one-cycle enable every DIV clocks
`timescale 1ns/1ns
module sfc_tick_div #(
	parameter int unsigned DIV = 100
) (
	input wire logic aclk,
	input wire logic aresetn,
	output logic tick
);
	logic [15:0] cnt_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt_reg == 16'(DIV - 1)) begin
			cnt_reg <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
			tick <= 1'b0;
		end
	end

endmodule

// ==== verif/sfc_hall_model.sv ====
// Hall sensor and bridge watch model for the fan commutator bench
`timescale 1ns/1ns
module sfc_hall_model (
	input wire logic aclk,
	input wire logic phase_b_cmd,
	input wire logic low_side_drive_a,
	input wire logic low_side_drive_b,
	input wire logic high_side_drive_a_oe,
	input wire logic high_side_drive_b_oe,
	output logic [sfc_pkg::CODE_W-1:0] hall_pos_level,
	output logic [sfc_pkg::CODE_W-1:0] hall_neg_level,
	output logic bridge_fault
);
	import sfc_pkg::*;
	logic a_on;
	logic b_on;
	assign a_on = low_side_drive_a | high_side_drive_a_oe;
	assign b_on = low_side_drive_b | high_side_drive_b_oe;
	initial begin
		hall_pos_level = 8'h5F;
		hall_neg_level = 8'h7D;
		bridge_fault = 1'h0;
	end
	// Sensor levels: positive above negative for phase B
	always @(posedge aclk) begin
		hall_pos_level <= phase_b_cmd ? 8'h9B : 8'h5F;
		hall_neg_level <= 8'h7D;
	end
	// Both phases energised at once would short the bridge
	always @(posedge aclk) begin
		if (a_on && b_on) begin
			bridge_fault <= 1'h1;
		end
	end
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the fan commutator
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
	err_count++; $display("unexpected %s exp %0h got %0h", nm, e, g); \
	end end
module tb_top;
	import sfc_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, hall_b = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic lsa, lsb, hsa, hsb, tach_oe, lock_oe, fault;
	logic [7:0] hpos, hneg;
	int err_count = 0;
	int tests_run = 0;

	always #5 aclk = ~aclk;

	sfc_commutator #(.LOCK_US(120), .ON_US(5), .OFF_US(60)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.hall_pos_level(hpos), .hall_neg_level(hneg),
		.low_side_drive_a(lsa), .low_side_drive_b(lsb),
		.high_side_drive_a_oe(hsa), .high_side_drive_b_oe(hsb),
		.tach_pulse_out_oe(tach_oe), .rotor_locked_oe(lock_oe));

	sfc_hall_model u_hall (.aclk(aclk), .phase_b_cmd(hall_b),
		.low_side_drive_a(lsa), .low_side_drive_b(lsb),
		.high_side_drive_a_oe(hsa), .high_side_drive_b_oe(hsb),
		.hall_pos_level(hpos), .hall_neg_level(hneg), .bridge_fault(fault));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic ls(input logic b);
		return b ? lsb : lsa;
	endfunction
	function automatic logic hs(input logic b);
		return b ? hsb : hsa;
	endfunction

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] re);
		bit aw_ok;
		bit w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'h1) begin
				aw_ok = 1;
				awvalid <= 1'h0;
			end
			if (!w_ok && wready === 1'h1) begin
				w_ok = 1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'h1);
		`CHK("bresp", re, bresp)
		bready <= 1'h0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge aclk); while (rvalid !== 1'h1);
		d = rdata;
		rready <= 1'h0;
	endtask

	// Flip the sensor and time the gap until the new phase drives
	task automatic commutate(input int us);
		int n;
		bit quiet;
		n = 0;
		quiet = 1;
		@(posedge aclk);
		hall_b <= !hall_b;
		do begin
			@(posedge aclk);
			n++;
			if (n > 3 && hs(hall_b) !== 1'h1 && {lsa, lsb, hsa, hsb} !== 4'h0)
				quiet = 0;
		end while (hs(hall_b) !== 1'h1 && n < 20000);
		`CHK("delay", 1'h1, n >= us * 100 - 100 && n <= us * 100 + 10)
		`CHK("gap quiet", 1'h1, quiet)
		`CHK("tach", !hall_b, tach_oe)
		`CHK("idle high side", 1'h0, hs(!hall_b))
		`CHK("idle low side", 1'h0, ls(!hall_b))
	endtask

	task automatic count_hi(input int cyc, output int hi);
		hi = 0;
		repeat (4) @(posedge aclk);
		repeat (cyc) begin
			@(posedge aclk);
			hi += (ls(hall_b) === 1'h1);
		end
	endtask

	// One full PWM period from rise to rise, and its high time
	task automatic pulse(output int per, output int hi);
		per = 0;
		hi = 0;
		do @(posedge aclk); while (ls(hall_b) !== 1'h0);
		do @(posedge aclk); while (ls(hall_b) !== 1'h1);
		do begin
			@(posedge aclk);
			per++;
			hi++;
		end while (ls(hall_b) === 1'h1);
		do begin
			@(posedge aclk);
			per++;
		end while (ls(hall_b) !== 1'h1);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs;
		logic [31:0] d;
		axi_rd(OFS_SPEED, d);
		`CHK("speed reset", 32'h00, d)
		axi_rd(OFS_MIN_SPEED, d);
		`CHK("min reset", 32'hFA, d)
		axi_rd(OFS_DELAY, d);
		`CHK("delay reset", 32'h0, d)
		axi_rd(OFS_STATUS, d);
		`CHK("status reset", 6'h04, d[5:0])
		axi_wr(OFS_STATUS, 32'hFF, RESP_OKAY);
		axi_rd(OFS_STATUS, d);
		`CHK("status ro", 6'h04, d[5:0])
		axi_wr(8'h10, 32'h5, RESP_SLVERR);
		axi_rd(8'h10, d);
		`CHK("unmapped", 32'h0, d)
		`CHK("rresp", RESP_SLVERR, rresp)
		axi_wr(OFS_SPEED, 32'h1AB, RESP_OKAY);
		axi_rd(OFS_SPEED, d);
		`CHK("speed field", 32'hAB, d)
		axi_wr(OFS_SPEED, 32'h0, RESP_OKAY);
		$display("test regs done");
	endtask

	task automatic t_delays;
		int sel_tab[5] = '{0, 4, 3, 2, 1};
		int us_tab[5] = '{100, 168, 120, 40, 28};
		for (int i = 0; i < 5; i++) begin
			axi_wr(OFS_DELAY, sel_tab[i], RESP_OKAY);
			commutate(us_tab[i]);
		end
		$display("test delays done");
	endtask

	task automatic t_pwm;
		int per;
		int hi;
		count_hi(1000, hi);
		`CHK("full drive", 1000, hi)
		axi_wr(OFS_SPEED, 32'hA0, RESP_OKAY);
		count_hi(1000, hi);
		`CHK("drive off", 0, hi)
		axi_wr(OFS_SPEED, 32'h64, RESP_OKAY);
		commutate(28);
		pulse(per, hi);
		`CHK("period", 1'h1, per >= 4050 && per <= 4150)
		`CHK("duty", 1'h1, hi >= 1950 && hi <= 2150)
		axi_wr(OFS_SPEED, 32'hA0, RESP_OKAY);
		axi_wr(OFS_MIN_SPEED, 32'h64, RESP_OKAY);
		commutate(28);
		pulse(per, hi);
		`CHK("min clamp", 1'h1, hi >= 1950 && hi <= 2150)
		axi_wr(OFS_MIN_SPEED, 32'hFA, RESP_OKAY);
		axi_wr(OFS_SPEED, 32'h0, RESP_OKAY);
		$display("test pwm done");
	endtask

	task automatic t_lock;
		int n;
		bit quiet;
		logic [31:0] d;
		commutate(28);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (lock_oe !== 1'h0 && n < 20000);
		`CHK("lock time", 1'h1, n >= 11900 && n <= 12010)
		axi_rd(OFS_STATUS, d);
		`CHK("lock status", 6'h11, d[5:0])
		n = 0;
		quiet = 1;
		do begin
			@(posedge aclk);
			n++;
			if ((hsa | hsb) !== 1'h1 && {lsa, lsb, hsa, hsb} !== 4'h0)
				quiet = 0;
		end while ((hsa | hsb) !== 1'h1 && n < 20000);
		`CHK("wait time", 1'h1, n >= 5880 && n <= 6010)
		`CHK("wait quiet", 1'h1, quiet)
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while ((hsa | hsb) === 1'h1 && n < 5000);
		`CHK("restart time", 1'h1, n >= 390 && n <= 510)
		`CHK("flag held", 1'h0, lock_oe)
		commutate(28);
		`CHK("lock ended", 1'h1, lock_oe)
		$display("test lock done");
	endtask

	// ---------------------------------------------------------------
	// Main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		`CHK("reset drive", 4'h0, {lsa, lsb, hsa, hsb})
		t_regs();
		t_delays();
		t_pwm();
		t_lock();
		`CHK("bridge fault", 1'h0, fault)
		give_verdict();
	end

	initial begin
		repeat (100000) @(posedge aclk);
		err_count++;
		give_verdict();
	end
endmodule
